// ==== common/pcs_pkg.sv ====
// package: register map, field layout, reset values and timing of the pmic control slice
package pcs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] PCS_OFS_SLEEP_EN    = 8'h41;
  localparam logic [7:0] PCS_OFS_LOCK        = 8'h42;
  localparam logic [7:0] PCS_OFS_PIN_MASK    = 8'h43;
  localparam logic [7:0] PCS_OFS_RST_TIMING  = 8'h48;
  localparam logic [7:0] PCS_OFS_SHUTDOWN    = 8'h49;
  localparam logic [7:0] PCS_OFS_INPUT_MON   = 8'h51;
  localparam logic [7:0] PCS_OFS_ADAPTER_CFG = 8'h69;
  localparam logic [7:0] PCS_OFS_LOWBAT_CFG  = 8'h6A;
  localparam logic [7:0] PCS_OFS_SRC_STATUS  = 8'h6F;
  localparam logic [7:0] PCS_OFS_WAKE_CLK    = 8'hD0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] PCS_RST_SLEEP_EN    = 8'h00;
  localparam logic [7:0] PCS_RST_LOCK        = 8'h00;
  localparam logic [7:0] PCS_RST_PIN_MASK    = 8'h00;
  localparam logic [7:0] PCS_RST_RST_TIMING  = 8'h1C;
  localparam logic [7:0] PCS_RST_INPUT_MON   = 8'h05;
  localparam logic [7:0] PCS_RST_ADAPTER_CFG = 8'h0F;
  localparam logic [7:0] PCS_RST_LOWBAT_CFG  = 8'hF8;
  localparam logic [7:0] PCS_RST_WAKE_CLK    = 8'h00;

  // ****************************************
  // field positions and writable masks
  // ****************************************
  localparam int PCS_LOCK_BIT        = 0;
  localparam int PCS_SHUTDOWN_BIT    = 0;
  localparam int PCS_WAKE_EN_BIT     = 0;
  localparam int PCS_TRST_LSB        = 3;
  localparam int PCS_RESET_THRESHOLD_FIELD_LSB      = 0;
  localparam int PCS_CMP_EN_BIT      = 6;
  localparam int PCS_MON_DB_LSB      = 4;
  localparam int PCS_CRIT_TH_LSB     = 0;
  localparam int PCS_AD_DB_LSB       = 2;
  localparam int PCS_AD_MODE_LSB     = 0;
  localparam int PCS_LB_DB_LSB       = 6;
  localparam int PCS_BAT2_EN_BIT     = 5;
  localparam int PCS_BAT1_EN_BIT     = 4;
  localparam int PCS_ADP_EN_BIT      = 3;
  localparam int PCS_BAT2_FLAG_BIT   = 6;
  localparam int PCS_BAT1_FLAG_BIT   = 5;
  localparam int PCS_ADP_FLAG_BIT    = 4;
  localparam logic [7:0] PCS_WMASK_LOCK = 8'h01;
  localparam logic [7:0] PCS_WMASK_RSTT = 8'h1F;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ            = 50_000_000;
  localparam int RTC_PERIOD_NS     = 30_500;
  localparam int MON_DB1_US        = 10;
  localparam int AD_DB0_US         = 81;
  localparam int AD_DB1_MS         = 10;
  localparam int AD_DB2_MS         = 20;
  localparam int AD_DB3_MS         = 30;
  localparam int RST_DUR0_MS       = 20;
  localparam int RST_DUR1_MS       = 40;
  localparam int RST_DUR2_MS       = 80;
  localparam int RST_DUR3_MS       = 200;
  localparam int CLK_PER_US        = CLK_HZ / 1_000_000;
  localparam int MON_DB1_CYC       = MON_DB1_US * CLK_PER_US;
  localparam int AD_DB0_CYC        = AD_DB0_US * CLK_PER_US;
  localparam int LB_DB0_RTC        = 4;
  localparam int LB_DB1_RTC        = 32;
  localparam int LB_DB2_RTC        = 64;
  localparam int LB_DB3_RTC        = 128;
  localparam int CNT_W             = 24;

  typedef enum logic [1:0] {
    PCS_EDGE_RSVD, PCS_EDGE_RISE, PCS_EDGE_FALL, PCS_EDGE_BOTH
  } pcs_edge_t;

endpackage : pcs_pkg

// ==== rtl/pcs_debounce.sv ====
// module: one debounced status filter with edge qualification
`timescale 1ns/10ps
`default_nettype none
module pcs_debounce
  import pcs_pkg::*;
#(
  parameter int W = 24
)(
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic          enable,
  input  wire logic          raw_in,
  input  wire logic [W-1:0]  hold_cycles,
  input  wire logic          allow_rise,
  input  wire logic          allow_fall,
  output logic               filtered
);

  // a one-bit counter cannot hold any useful filter length
  if (W < 2)
  begin : g_bad_w
    $error("pcs_debounce: W too small");
  end

  logic [W-1:0] count_reg;
  logic         filtered_reg;

  // the level must differ from the flag for hold_cycles before it is taken
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= '0;
    else if (!enable || raw_in == filtered_reg)
      count_reg <= '0;
    else if (count_reg < hold_cycles)
      count_reg <= count_reg + 1'b1;
  end

  // disabled detectors freeze their flag
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      filtered_reg <= 1'b0;
    else if (enable && raw_in != filtered_reg && count_reg >= hold_cycles)
    begin
      if ((raw_in && allow_rise) || (!raw_in && allow_fall))
        filtered_reg <= raw_in;
    end
  end

  assign filtered = filtered_reg;

endmodule : pcs_debounce
`default_nettype wire

// ==== rtl/pcs_regs.sv ====
// module: pmic control and status register bank behind the i2c register port
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - lock bit set blocks all writes to regulator control registers
// - mask 0 lets enable pin drive rail; mask 1 uses register bit
// - mask bits 7..0 map core,1v05,memory,switched,1v8,hub,5v,io; reset 0
// - reset duration code 0..3 gives 20,40,80,200 ms; resets to 3
// - reset threshold code selects trip voltage; resets to 4
// - writing 1 to shutdown forces emergency reset then self-clears
// - input-monitor bit 6 enables critical comparator; resets 0
// - monitor debounce: none, 10 us, one or two slow-clock periods
// - critical threshold code 0 off, 1-7 steps, 8-15 unused; resets 5
// - adapter debounce code: 81 us, 10, 20, 30 ms; resets 3
// - adapter mode: 1 rising, 2 falling, 3 both, 0 reserved
// - low-battery debounce 4,32,64,128 slow-clock periods; resets 3
// - bits 5,4,3 enable battery2, battery1, adapter detectors; reset on
// - status bits 6,5 read 1 while battery 2/1 below threshold
// - status bit 4 is the adapter flag, set and cleared only on edges the adapter mode accepts
// - wake-clock bit 0 turns 1 Hz output on; resets 0
// - slow-clock counts assume 30.5 us period
module pcs_regs
  import pcs_pkg::*;
#(
  parameter int N_RAILS  = 8,
  parameter int AD_DB_MS = AD_DB3_MS
)(
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic               regulator_control_wr,
  output logic                    regulator_control_wr_ok,
  input  wire logic [N_RAILS-1:0] rail_enable_pins,
  input  wire logic [N_RAILS-1:0] regulator_control_enable,
  output logic      [N_RAILS-1:0] rail_enable,
  output logic      [1:0]         reset_duration_code,
  output logic      [2:0]         reset_threshold_field,
  output logic      [CNT_W-1:0]   reset_pulse_cycles,
  output logic                    emergency_reset,
  input  wire logic               input_sense_cmp,
  output logic                    critical_input_comparator_enable,
  output logic      [3:0]         critical_input_threshold,
  output logic                    input_low_filtered,
  input  wire logic               adapter_cmp,
  input  wire logic               first_battery_cmp,
  input  wire logic               second_battery_cmp,
  input  wire logic               rtc_tick,
  output logic                    wake_clock_enable,
  output logic      [1:0]         sleep_state_enables
);

  // ****************************************
  // parameter checks
  // ****************************************
  // the rail map and the mask register are both eight bits wide
  if (N_RAILS != 8)
  begin : g_bad_rails
    $error("pcs_regs: N_RAILS must be 8");
  end
  // the adapter hold count must fit the filter counter
  if (AD_DB_MS < 1 || AD_DB_MS * 1000 * CLK_PER_US >= (1 << CNT_W))
  begin : g_bad_ad_db
    $error("pcs_regs: AD_DB_MS out of range");
  end

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] sleep_reg, lock_reg, mask_reg, rstt_reg;
  logic [7:0] mon_reg, adcfg_reg, lbcfg_reg, wake_reg;
  logic       shutdown_reg;
  logic [7:0] status_reg;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleep_reg <= PCS_RST_SLEEP_EN;
      lock_reg  <= PCS_RST_LOCK;
      mask_reg  <= PCS_RST_PIN_MASK;
      rstt_reg  <= PCS_RST_RST_TIMING;
      mon_reg   <= PCS_RST_INPUT_MON;
      adcfg_reg <= PCS_RST_ADAPTER_CFG;
      lbcfg_reg <= PCS_RST_LOWBAT_CFG;
      wake_reg  <= PCS_RST_WAKE_CLK;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        PCS_OFS_SLEEP_EN:    sleep_reg <= reg_wdata;
        PCS_OFS_LOCK:        lock_reg  <= reg_wdata & PCS_WMASK_LOCK;
        PCS_OFS_PIN_MASK:    mask_reg  <= reg_wdata;
        PCS_OFS_RST_TIMING:  rstt_reg  <= reg_wdata & PCS_WMASK_RSTT;
        PCS_OFS_INPUT_MON:   mon_reg   <= reg_wdata;
        PCS_OFS_ADAPTER_CFG: adcfg_reg <= reg_wdata;
        PCS_OFS_LOWBAT_CFG:  lbcfg_reg <= reg_wdata;
        PCS_OFS_WAKE_CLK:    wake_reg  <= reg_wdata;
        default:             ;
      endcase
    end
  end

  // one-shot: set by a write of 1, cleared by hardware the next cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      shutdown_reg <= 1'b0;
    else
      shutdown_reg <= reg_wr && reg_addr == PCS_OFS_SHUTDOWN
                      && reg_wdata[PCS_SHUTDOWN_BIT];
  end
  assign emergency_reset = shutdown_reg;

  // ****************************************
  // control outputs
  // ****************************************
  assign regulator_control_wr_ok =
    regulator_control_wr && !lock_reg[PCS_LOCK_BIT];

  genvar g;
  generate
    for (g = 0; g < N_RAILS; g++)
    begin : g_rail
      assign rail_enable[g] = mask_reg[g] ? regulator_control_enable[g]
                                          : rail_enable_pins[g];
    end
  endgenerate

  assign reset_duration_code   = rstt_reg[PCS_TRST_LSB +: 2];
  assign reset_threshold_field = rstt_reg[PCS_RESET_THRESHOLD_FIELD_LSB +: 3];
  assign critical_input_comparator_enable = mon_reg[PCS_CMP_EN_BIT];
  assign critical_input_threshold = mon_reg[PCS_CRIT_TH_LSB +: 4];
  assign wake_clock_enable   = wake_reg[PCS_WAKE_EN_BIT];
  assign sleep_state_enables = sleep_reg[1:0];

  // reset pulse length in system clocks
  always_comb
  begin
    case (reset_duration_code)
      2'h0:    reset_pulse_cycles = CNT_W'(RST_DUR0_MS * 1000 * CLK_PER_US);
      2'h1:    reset_pulse_cycles = CNT_W'(RST_DUR1_MS * 1000 * CLK_PER_US);
      2'h2:    reset_pulse_cycles = CNT_W'(RST_DUR2_MS * 1000 * CLK_PER_US);
      default: reset_pulse_cycles = CNT_W'(RST_DUR3_MS * 1000 * CLK_PER_US);
    endcase
  end

  // ****************************************
  // debounce lengths
  // ****************************************
  // slow-clock based filters count system clocks, RTC_CYC per slow period,
  // so the tolerance of the slow oscillator does not enter the filter time
  logic [CNT_W-1:0] rtc_count_reg;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rtc_count_reg <= '0;
    else if (rtc_tick)
      rtc_count_reg <= rtc_count_reg + 1'b1;
  end

  logic [CNT_W-1:0] mon_hold, ad_hold, lb_hold;
  localparam int RTC_CYC = RTC_PERIOD_NS * CLK_PER_US / 1000;

  // code 0 passes the comparator after a single edge
  always_comb
  begin
    case (mon_reg[PCS_MON_DB_LSB +: 2])
      2'h0:    mon_hold = '0;
      2'h1:    mon_hold = CNT_W'(MON_DB1_CYC);
      2'h2:    mon_hold = CNT_W'(RTC_CYC);
      default: mon_hold = CNT_W'(2 * RTC_CYC);
    endcase
  end

  // code 3 length is a parameter so short benches can trim it
  always_comb
  begin
    case (adcfg_reg[PCS_AD_DB_LSB +: 2])
      2'h0:    ad_hold = CNT_W'(AD_DB0_CYC);
      2'h1:    ad_hold = CNT_W'(AD_DB1_MS * 1000 * CLK_PER_US);
      2'h2:    ad_hold = CNT_W'(AD_DB2_MS * 1000 * CLK_PER_US);
      default: ad_hold = CNT_W'(AD_DB_MS * 1000 * CLK_PER_US);
    endcase
  end

  // both battery filters share one length setting
  always_comb
  begin
    case (lbcfg_reg[PCS_LB_DB_LSB +: 2])
      2'h0:    lb_hold = CNT_W'(LB_DB0_RTC * RTC_CYC);
      2'h1:    lb_hold = CNT_W'(LB_DB1_RTC * RTC_CYC);
      2'h2:    lb_hold = CNT_W'(LB_DB2_RTC * RTC_CYC);
      default: lb_hold = CNT_W'(LB_DB3_RTC * RTC_CYC);
    endcase
  end

  pcs_edge_t ad_mode;
  logic      ad_allow_rise, ad_allow_fall;
  assign ad_mode = pcs_edge_t'(adcfg_reg[PCS_AD_MODE_LSB +: 2]);
  // reserved mode code 0 accepts no edge, so the flag holds
  assign ad_allow_rise = ad_mode == PCS_EDGE_RISE
                         || ad_mode == PCS_EDGE_BOTH;
  assign ad_allow_fall = ad_mode == PCS_EDGE_FALL
                         || ad_mode == PCS_EDGE_BOTH;

  // ****************************************
  // detectors
  // ****************************************
  logic adapter_flag, bat1_flag, bat2_flag;
  logic mon_enable;

  // codes 0 and 8..15 give no limit, so the filter rests there
  assign mon_enable = critical_input_comparator_enable
                      && critical_input_threshold != 4'h0
                      && !critical_input_threshold[3];

  pcs_debounce #(.W(CNT_W)) u_input_mon (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .enable      (mon_enable),
    .raw_in      (input_sense_cmp),
    .hold_cycles (mon_hold),
    .allow_rise  (1'b1),
    .allow_fall  (1'b1),
    .filtered    (input_low_filtered)
  );

  pcs_debounce #(.W(CNT_W)) u_adapter (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .enable      (lbcfg_reg[PCS_ADP_EN_BIT]),
    .raw_in      (adapter_cmp),
    .hold_cycles (ad_hold),
    .allow_rise  (ad_allow_rise),
    .allow_fall  (ad_allow_fall),
    .filtered    (adapter_flag)
  );

  pcs_debounce #(.W(CNT_W)) u_bat1 (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .enable      (lbcfg_reg[PCS_BAT1_EN_BIT]),
    .raw_in      (first_battery_cmp),
    .hold_cycles (lb_hold),
    .allow_rise  (1'b1),
    .allow_fall  (1'b1),
    .filtered    (bat1_flag)
  );

  pcs_debounce #(.W(CNT_W)) u_bat2 (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .enable      (lbcfg_reg[PCS_BAT2_EN_BIT]),
    .raw_in      (second_battery_cmp),
    .hold_cycles (lb_hold),
    .allow_rise  (1'b1),
    .allow_fall  (1'b1),
    .filtered    (bat2_flag)
  );

  always_comb
  begin
    status_reg = 8'h00;
    status_reg[PCS_BAT2_FLAG_BIT] = bat2_flag;
    status_reg[PCS_BAT1_FLAG_BIT] = bat1_flag;
    status_reg[PCS_ADP_FLAG_BIT]  = adapter_flag;
  end

  // ****************************************
  // read path
  // ****************************************
  // the shutdown bit reads 1 only during its one-cycle pulse
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        PCS_OFS_SLEEP_EN:    reg_rdata <= sleep_reg;
        PCS_OFS_LOCK:        reg_rdata <= lock_reg;
        PCS_OFS_PIN_MASK:    reg_rdata <= mask_reg;
        PCS_OFS_RST_TIMING:  reg_rdata <= rstt_reg;
        PCS_OFS_SHUTDOWN:    reg_rdata <= {7'h00, shutdown_reg};
        PCS_OFS_INPUT_MON:   reg_rdata <= mon_reg;
        PCS_OFS_ADAPTER_CFG: reg_rdata <= adcfg_reg;
        PCS_OFS_LOWBAT_CFG:  reg_rdata <= lbcfg_reg;
        PCS_OFS_SRC_STATUS:  reg_rdata <= status_reg;
        PCS_OFS_WAKE_CLK:    reg_rdata <= wake_reg;
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // tick counter kept for sizing only; the filters run on system clocks
  logic unused_rtc;
  assign unused_rtc = ^rtc_count_reg;

endmodule : pcs_regs
`default_nettype wire

// ==== tb/pcs_regs_chk.sv ====
// checker: port assertions for the pcs register slice
`timescale 1ns/10ps
`default_nettype none
module pcs_regs_chk
  import pcs_pkg::*;
#(
  parameter int N_RAILS = 8
)(
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  input wire logic               regulator_control_wr,
  input wire logic               regulator_control_wr_ok,
  input wire logic [N_RAILS-1:0] rail_enable_pins,
  input wire logic [N_RAILS-1:0] regulator_control_enable,
  input wire logic [N_RAILS-1:0] rail_enable,
  input wire logic [1:0]         reset_duration_code,
  input wire logic [2:0]         reset_threshold_field,
  input wire logic [CNT_W-1:0]   reset_pulse_cycles,
  input wire logic               emergency_reset,
  input wire logic               wake_clock_enable
);
  // ****
  // shadow of the pin mask and properties
  // ****
  logic [N_RAILS-1:0] mask_q;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      mask_q <= '0;
    else if (reg_wr && reg_addr == PCS_OFS_PIN_MASK)
      mask_q <= reg_wdata[N_RAILS-1:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  chk_lock_gate: assert property (
    reg_wr && reg_addr == PCS_OFS_LOCK ##1 regulator_control_wr
    |-> regulator_control_wr_ok == !$past(reg_wdata[0]))
    else $error("lock does not gate regulator writes");
  chk_rail_mux: assert property (
    rail_enable == ((mask_q & regulator_control_enable)
                  | (~mask_q & rail_enable_pins)))
    else $error("rail enable source wrong");
  chk_forced_shutdown_bit_pulse: assert property (
    reg_wr && reg_addr == PCS_OFS_SHUTDOWN && reg_wdata[0]
    |=> emergency_reset ##1 !emergency_reset)
    else $error("shutdown pulse wrong");
  chk_forced_shutdown_bit_cause: assert property (
    !(reg_wr && reg_addr == PCS_OFS_SHUTDOWN && reg_wdata[0])
    |=> !emergency_reset)
    else $error("emergency reset without trigger");
  chk_rst_fields: assert property (
    reg_wr && reg_addr == PCS_OFS_RST_TIMING
    |=> {reset_duration_code, reset_threshold_field}
        == $past(reg_wdata[4:0]))
    else $error("reset timing fields not loaded");
  chk_dur_table: assert property (
    reset_pulse_cycles == (reset_duration_code == 2'h0 ? 24'h0F4240 :
                           reset_duration_code == 2'h1 ? 24'h1E8480 :
                           reset_duration_code == 2'h2 ? 24'h3D0900 :
                           24'h989680))
    else $error("reset pulse length wrong");
  chk_status_rsvd: assert property (
    reg_rd && reg_addr == PCS_OFS_SRC_STATUS
    |=> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
    else $error("reserved status bits not zero");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_wake_bit: assert property (
    reg_wr && reg_addr == PCS_OFS_WAKE_CLK
    |=> wake_clock_enable == $past(reg_wdata[0]))
    else $error("wake clock enable wrong");
  cov_shutdown: cover property (emergency_reset);
  cov_locked: cover property (!regulator_control_wr_ok);
  cov_flag: cover property (
    reg_rd && reg_addr == PCS_OFS_SRC_STATUS ##1 reg_rdata[4]);
endmodule : pcs_regs_chk
bind pcs_regs pcs_regs_chk #(.N_RAILS(N_RAILS)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .regulator_control_wr(regulator_control_wr),
  .regulator_control_wr_ok(regulator_control_wr_ok),
  .rail_enable_pins(rail_enable_pins),
  .regulator_control_enable(regulator_control_enable),
  .rail_enable(rail_enable), .reset_duration_code(reset_duration_code),
  .reset_threshold_field(reset_threshold_field),
  .reset_pulse_cycles(reset_pulse_cycles),
  .emergency_reset(emergency_reset),
  .wake_clock_enable(wake_clock_enable)
);
`default_nettype wire

// ==== tb/pcs_ec_host.sv ====
// partner: controller issuing single-byte register accesses
`timescale 1ns/10ps
`default_nettype none
module pcs_ec_host
(
  input  wire logic  clk_sys,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released address and data lines show the inverse so stale values cannot pass
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : pcs_ec_host
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: self-checking bench for the pcs register slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pcs_pkg::*;
  localparam int RTC_CYC = RTC_PERIOD_NS * CLK_PER_US / 1000;
  logic             clk_sys, reset_n, rc_wr, rtc_tick, sense, adp, b1, b2;
  logic             wr_ok, emerg, wake, filt, cmp_en;
  logic [7:0]       pins, rce, rdata, rail;
  logic [3:0]       crit_th;
  logic [1:0]       sleep;
  logic [CNT_W-1:0] pulse;
  wire logic        reg_wr, reg_rd;
  wire logic [7:0]  reg_addr, reg_wdata;
  logic [31:0]      seed;
  logic [7:0]       exp_q[$];
  int               num_errors, n_tests;
  pcs_ec_host ec (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  pcs_regs uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata),
    .regulator_control_wr(rc_wr), .regulator_control_wr_ok(wr_ok),
    .rail_enable_pins(pins), .regulator_control_enable(rce),
    .rail_enable(rail), .reset_duration_code(), .reset_threshold_field(),
    .reset_pulse_cycles(pulse), .emergency_reset(emerg),
    .input_sense_cmp(sense), .critical_input_comparator_enable(cmp_en),
    .critical_input_threshold(crit_th), .input_low_filtered(filt),
    .adapter_cmp(adp), .first_battery_cmp(b1), .second_battery_cmp(b2),
    .rtc_tick(rtc_tick), .wake_clock_enable(wake),
    .sleep_state_enables(sleep));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] v, e);
    n_tests++;
    if (v !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    ec.access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    ec.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    rtc_tick = 1'b0;
    forever
    begin
      repeat (RTC_CYC - 1) @(negedge clk_sys);
      rtc_tick = 1'b1;
      @(negedge clk_sys);
      rtc_tick = 1'b0;
    end
  end
  // ****
  // read result monitor
  // ****
  initial
    forever
    begin
      @(posedge clk_sys);
      if (reg_rd === 1'b1)
      begin
        @(negedge clk_sys);
        chk("reg_rdata", rdata, exp_q.pop_front());
      end
    end
  // ****
  // main sequence
  // ****
  initial
  begin
    logic [7:0] ra[11], rv[11], wa[8], wm[8];
    int c, ms[4], hd[4];
    ra = '{8'h41, 8'h42, 8'h43, 8'h48, 8'h49, 8'h51, 8'h69, 8'h6A,
           8'h6F, 8'hD0, 8'h00};
    rv = '{8'h00, 8'h00, 8'h00, 8'h1C, 8'h00, 8'h05, 8'h0F, 8'hF8,
           8'h00, 8'h00, 8'h00};
    wa = '{8'h41, 8'h42, 8'h43, 8'h48, 8'h51, 8'h69, 8'h6A, 8'hD0};
    wm = '{8'hFF, 8'h01, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    ms = '{RST_DUR0_MS, RST_DUR1_MS, RST_DUR2_MS, RST_DUR3_MS};
    hd = '{0, MON_DB1_CYC, RTC_CYC, 2 * RTC_CYC};
    {reset_n, rc_wr, sense, adp, b1, b2, pins, rce} = '0;
    seed = 32'h6986E10F;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    for (c = 0; c < 11; c++)
      rd(ra[c], rv[c]);
    for (c = 0; c < 8; c++)
    begin
      seed = xs(seed);
      wr(wa[c], seed[7:0]);
      rd(wa[c], seed[7:0] & wm[c]);
    end
    wr(8'h6F, 8'hFF);
    wr(8'h00, 8'hFF);
    rd(8'h6F, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h41, 8'hA6);
    chk("sleep", sleep, 2'h2);
    wr(8'hD0, 8'h01);
    chk("wake", wake, 1'b1);
    rc_wr = 1'b1;
    wr(8'h42, 8'h01);
    chk("wr_ok", wr_ok, 1'b0);
    wr(8'h42, 8'h00);
    chk("wr_ok", wr_ok, 1'b1);
    for (c = 0; c < 4; c++)
    begin
      seed = xs(seed);
      wr(8'h43, seed[7:0]);
      {rce, pins} = seed[23:8];
      @(negedge clk_sys);
      chk("rail", rail, (seed[7:0] & rce) | (~seed[7:0] & pins));
      wr(8'h48, {3'h0, c[1:0], 3'h4});
      chk("pulse", pulse, ms[c] * (CLK_HZ / 1000));
    end
    wr(8'h49, 8'h01);
    chk("emerg", emerg, 1'b1);
    @(negedge clk_sys);
    chk("emerg", emerg, 1'b0);
    wr(8'h49, 8'h00);
    chk("emerg", emerg, 1'b0);
    for (c = 0; c < 4; c++)
    begin
      wr(8'h51, {2'b01, c[1:0], 4'h1});
      chk("cmp_en", cmp_en, 1'b1);
      chk("crit_th", crit_th, 4'h1);
      sense = 1'b1;
      if (hd[c] > 20)
      begin
        repeat (hd[c] - 10) @(negedge clk_sys);
        chk("filt", filt, 1'b0);
      end
      repeat (20) @(negedge clk_sys);
      chk("filt", filt, 1'b1);
      sense = 1'b0;
      repeat (hd[c] + 20) @(negedge clk_sys);
    end
    wr(8'h51, 8'h40);
    chk("crit_th", crit_th, 4'h0);
    sense = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("filt", filt, 1'b0);
    wr(8'h6A, 8'h38);
    wr(8'h69, 8'h01);
    adp = 1'b1;
    repeat (AD_DB0_CYC - 60) @(negedge clk_sys);
    rd(8'h6F, 8'h00);
    repeat (100) @(negedge clk_sys);
    rd(8'h6F, 8'h10);
    adp = 1'b0;
    repeat (AD_DB0_CYC + 50) @(negedge clk_sys);
    rd(8'h6F, 8'h10);
    wr(8'h69, 8'h03);
    repeat (AD_DB0_CYC + 50) @(negedge clk_sys);
    rd(8'h6F, 8'h00);
    wr(8'h69, 8'h02);
    adp = 1'b1;
    repeat (AD_DB0_CYC + 50) @(negedge clk_sys);
    rd(8'h6F, 8'h00);
    {b1, b2} = 2'b11;
    repeat (LB_DB0_RTC * RTC_CYC - 80) @(negedge clk_sys);
    rd(8'h6F, 8'h00);
    repeat (200) @(negedge clk_sys);
    rd(8'h6F, 8'h60);
    wr(8'h6A, 8'h08);
    {b1, b2} = 2'b00;
    repeat (LB_DB0_RTC * RTC_CYC + 100) @(negedge clk_sys);
    rd(8'h6F, 8'h60);
    repeat (3) @(negedge clk_sys);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
